// [dv/dsr_host_model.sv]
// Purpose: Host side: master clock, framed shift clock, select, word capture.
// Assumes: One read per ready low period, 24 result bits plus 2 chain bits.
// Notes: A released data line reads as the inverse of the last bit.
`timescale 1ns/1ps
module dsr_host_model (
  input wire ready_n_i,
  input wire data_i,
  input wire data_oe_i,
  output reg mclk_o,
  output reg sclk_o,
  output reg sel_n_o,
  output reg [25:0] word_o,
  output reg vld_o
);
  integer i;
  initial begin
    mclk_o = 1'b0;
    #3;
    forever begin
      #600 mclk_o = 1'b1;
      #400 mclk_o = 1'b0;
    end
  end
  // Shift clock idles high and runs only inside a read
  initial begin
    {sclk_o, sel_n_o, vld_o, word_o} = {3'b110, 26'h0};
    forever begin
      @(negedge ready_n_i);
      #22 sel_n_o = 1'b0;
      #60;
      for (i = 0; i < 26; i = i + 1) begin
        word_o = {word_o[24:0], data_oe_i ? data_i : ~word_o[0]};
        sclk_o = 1'b0;
        #62.5 sclk_o = 1'b1;
        #62.5;
      end
      sel_n_o = 1'b1;
      vld_o = 1'b1;
      #10 vld_o = 1'b0;
    end
  end
endmodule

// [dv/dsr_readout_monitor.sv]
// Purpose: Port checks for the converter serial readout.
// Assumes: Master clock high for 40 system cycles.
// Notes: Period check skips the first frame after power-down.
`timescale 1ns/1ps
module dsr_readout_monitor #(parameter RATE_N = 1) (
  input wire clk_sys_i,
  input wire rst_b_i,
  input wire master_clk_i,
  input wire shift_clk_i,
  input wire select_n_i,
  input wire sync_powerdown_n_i,
  input wire ready_n_o,
  input wire serial_result_out_o,
  input wire serial_result_out_oe_o,
  input wire powered_down_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  reg [7:0] mcnt;
  reg mp, rp, fresh;
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      {mcnt, mp, rp, fresh} <= {8'h0, 3'b011};
    end else begin
      mcnt <= ((rp & ~ready_n_o) ? 8'h0 : mcnt) + {7'h0, master_clk_i & ~mp};
      {mp, rp} <= {master_clk_i, ready_n_o};
      fresh <= powered_down_o | (fresh & ~(rp & ~ready_n_o));
    end
  end
  a_pd_ready_high: assert property (powered_down_o && $past(powered_down_o, 2) |-> ready_n_o)
    else $error("ready low in power-down");
  a_sync_enters_pd: assert property ($rose(master_clk_i) && !sync_powerdown_n_i
    |-> ##[1:6] powered_down_o) else $error("no power-down");
  a_period_count: assert property ($fell(ready_n_o) && !fresh |-> mcnt == 8 * RATE_N)
    else $error("bad ready period");
  a_rise_in_high: assert property ($rose(ready_n_o) && sync_powerdown_n_i
    |-> master_clk_i && $past(master_clk_i, 8)) else $error("late ready rise");
  a_fall_in_low: assert property ($fell(ready_n_o)
    |-> !master_clk_i && $past(master_clk_i, 45)) else $error("bad ready fall");
  a_oe_on_select: assert property ($fell(select_n_i)
    |-> ##[2:4] serial_result_out_oe_o) else $error("no drive");
  a_oe_off_deselect: assert property ($rose(select_n_i)
    |-> ##[2:4] !serial_result_out_oe_o) else $error("no release");
  a_bit_on_shift: assert property ($changed(serial_result_out_o) &&
    serial_result_out_oe_o |-> !shift_clk_i) else $error("bit moved off edge");
endmodule
bind dsr_readout dsr_readout_monitor #(.RATE_N(RATE_N)) mon (.clk_sys_i(clk_sys_i),
  .rst_b_i(rst_b_i), .master_clk_i(master_clk_i), .shift_clk_i(shift_clk_i),
  .select_n_i(select_n_i), .sync_powerdown_n_i(sync_powerdown_n_i), .ready_n_o(ready_n_o),
  .serial_result_out_o(serial_result_out_o),
  .serial_result_out_oe_o(serial_result_out_oe_o), .powered_down_o(powered_down_o));

// [dv/test_dsr_readout.sv]
// Purpose: Self-checking bench for the converter serial readout.
// Assumes: Host model makes the master and shift clocks.
// Notes: Each loaded word is queued with its chain bit, matched per read.
`timescale 1ns/1ps
module test_dsr_readout;
  reg clk_sys_i = 1'b0;
  reg rst_b_i = 1'b0;
  reg sync_n = 1'b1;
  reg chain = 1'b0;
  reg [23:0] result = 24'h0;
  reg [31:0] seed = 32'heefb069c;
  reg [25:0] expq[$];
  wire take, rdy_n, serial_result_out, oe, pd, mclk, sclk, sel_n, vld;
  wire [25:0] word;
  wire take4, rdy4_n, pd4;
  reg [7:0] n1 = 8'h0;
  reg armed = 1'b0;
  integer error_cnt = 0;
  integer compares = 0;
  integer words = 0;
  integer k;
  always #5 clk_sys_i = ~clk_sys_i;
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  dsr_readout #(.RATE_N(1)) dut (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
    .master_clk_i(mclk), .shift_clk_i(sclk), .select_n_i(sel_n), .chain_serial_in_i(chain),
    .sync_powerdown_n_i(sync_n), .result_i(result), .result_take_o(take), .ready_n_o(rdy_n),
    .serial_result_out_o(serial_result_out), .serial_result_out_oe_o(oe), .powered_down_o(pd));
  // Slow variant shares the pins; its strobe must pace one take per four
  dsr_readout #(.RATE_N(4)) dut4 (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
    .master_clk_i(mclk), .shift_clk_i(sclk), .select_n_i(sel_n), .chain_serial_in_i(chain),
    .sync_powerdown_n_i(sync_n), .result_i(result), .result_take_o(take4),
    .ready_n_o(rdy4_n), .serial_result_out_o(), .serial_result_out_oe_o(),
    .powered_down_o(pd4));
  dsr_host_model host (.ready_n_i(rdy_n), .data_i(serial_result_out), .data_oe_i(oe), .mclk_o(mclk),
    .sclk_o(sclk), .sel_n_o(sel_n), .word_o(word), .vld_o(vld));
  task chk(input string nm, input [25:0] seen, input [25:0] exp);
    compares = compares + 1;
    if (seen !== exp) begin
      error_cnt = error_cnt + 1;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task results;
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task wait_words(input integer n);
    for (k = 0; k < 20000 && words < n; k = k + 1) @(posedge clk_sys_i);
    if (words < n) begin
      error_cnt = error_cnt + 1;
      results;
    end
  endtask
  // New word and chain bit after each load; the chain bit then holds through the read
  always @(posedge clk_sys_i) if (take) begin
    seed = lfsr(seed);
    expq.push_back({result, seed[24], seed[24]});
    result <= seed[23:0];
    chain <= seed[24];
  end
  always @(posedge clk_sys_i) begin
    if (pd) begin
      n1 = 8'h0;
      armed = 1'b0;
    end
    if (take) n1 = n1 + 8'h1;
    if (take4) begin
      if (armed) chk("takes per slow period", {18'h0, n1}, 26'h4);
      n1 = 8'h0;
      armed = 1'b1;
    end
  end
  always @(posedge vld) begin
    words = words + 1;
    chk("word", word, expq.size() > 0 ? expq.pop_front() : ~word);
  end
  initial begin
    repeat (3) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    wait_words(5);
    $display("test stream done");
    sync_n <= 1'b0;
    repeat (300) @(posedge clk_sys_i);
    chk("power-down and ready", {22'h0, pd4, rdy4_n, pd, rdy_n}, 26'hf);
    sync_n <= 1'b1;
    wait_words(8);
    $display("test sync done");
    results;
  end
endmodule

// [verilog/dsr_consts.vh]
// Purpose: Shared constants for the decimating converter serial readout.
// Assumes: System clock of 100 MHz (10 ns period).
// Notes: Times are kept in ns; cycle counts derive from them.
`ifndef DSR_CONSTS_VH
`define DSR_CONSTS_VH

`define DSR_CLK_PERIOD_NS 10
`define DSR_WORD_BITS 24
`define DSR_MCLK_PER_UNIT 8
// Rising master clock edge to ready falling edge, typical
`define DSR_T_FALL_NS 510
// Rising master clock edge to ready rising edge, per rate variant
`define DSR_T_RISE_N1_NS 265
`define DSR_T_RISE_N2_NS 128
`define DSR_T_RISE_N4_NS 71
// Entering sync/power-down: master clock edge to ready high
`define DSR_T_SYNC_NS 20
// Longest times round down, never below one cycle
`define DSR_CYC_DOWN(t) (((t) / `DSR_CLK_PERIOD_NS) < 1 ? 1 : ((t) / `DSR_CLK_PERIOD_NS))
`define DSR_FALL_CYC `DSR_CYC_DOWN(`DSR_T_FALL_NS)
`define DSR_RISE_N1_CYC `DSR_CYC_DOWN(`DSR_T_RISE_N1_NS)
`define DSR_RISE_N2_CYC `DSR_CYC_DOWN(`DSR_T_RISE_N2_NS)
`define DSR_RISE_N4_CYC `DSR_CYC_DOWN(`DSR_T_RISE_N4_NS)
`define DSR_SYNC_CYC `DSR_CYC_DOWN(`DSR_T_SYNC_NS)

`endif

// [verilog/dsr_readout.v]
// Purpose: Ready strobe pacing and serial result shift-out of a 24-bit converter.
// Assumes: Master clock, shift clock, select, chain input and sync are pins,
//   sampled by the 100 MHz system clock; results arrive on a parallel port.
// Notes: Pin edges are seen two to three system cycles late after syncing.
`timescale 1ns/1ps
`include "dsr_consts.vh"

module dsr_readout #(
  parameter RATE_N = 1,
  parameter WORD_BITS = `DSR_WORD_BITS
) (
  input wire clk_sys_i,
  input wire rst_b_i,
  input wire master_clk_i,
  input wire shift_clk_i,
  input wire select_n_i,
  input wire chain_serial_in_i,
  input wire sync_powerdown_n_i,
  input wire [WORD_BITS-1:0] result_i,
  output reg result_take_o,
  output reg ready_n_o,
  output reg serial_result_out_o,
  output reg serial_result_out_oe_o,
  output reg powered_down_o
);
  // Decimation ratio and strobe high-pulse timing follow the rate variant
  // Cycle counts are worked out as integers, then cut to counter width
  localparam integer PERIOD_INT = RATE_N * `DSR_MCLK_PER_UNIT;
  localparam integer FALL_INT = `DSR_FALL_CYC;
  localparam integer RISE_INT = (RATE_N == 4) ? `DSR_RISE_N4_CYC :
                                (RATE_N == 2) ? `DSR_RISE_N2_CYC : `DSR_RISE_N1_CYC;
  localparam integer SYNC_INT = `DSR_SYNC_CYC;
  localparam [7:0] PERIOD_MCLK = PERIOD_INT[7:0];
  localparam [7:0] FALL_CYC = FALL_INT[7:0];
  localparam [7:0] RISE_CYC = RISE_INT[7:0];
  localparam [7:0] SYNC_CYC = SYNC_INT[7:0];
  // Down-count value at which the high pulse starts, timed from the same edge
  localparam [7:0] RISE_AT = FALL_CYC - RISE_CYC + 8'h01;

  localparam [1:0] ST_RUN = 2'd0;
  localparam [1:0] ST_FALLW = 2'd1;
  localparam [1:0] ST_RISEW = 2'd2;
  localparam [1:0] ST_DOWN = 2'd3;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  wire [3:0] pins_s;
  wire mclk_s;
  wire sclk_s;
  wire sel_n_s;
  wire sync_n_s;
  reg mclk_d;
  reg sclk_d;
  reg chain_d;

  // Clock pins reset high so no false edge follows reset
  dsr_sync2 #(.WIDTH(4), .RST_VAL(4'hf)) u_sync (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .async_i({master_clk_i, shift_clk_i, select_n_i, sync_powerdown_n_i}),
    .sync_o(pins_s)
  );
  assign mclk_s = pins_s[3];
  assign sclk_s = pins_s[2];
  assign sel_n_s = pins_s[1];
  assign sync_n_s = pins_s[0];

  // Chain input passes its own two stages
  reg chain_m;
  reg chain_s;
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      chain_m <= 1'b0;
      chain_s <= 1'b0;
    end else begin
      chain_m <= chain_serial_in_i;
      chain_s <= chain_m;
    end
  end

  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mclk_d <= 1'b1;
      sclk_d <= 1'b1;
      chain_d <= 1'b0;
    end else begin
      mclk_d <= mclk_s;
      sclk_d <= sclk_s;
      chain_d <= chain_s;
    end
  end

  wire mclk_rise = mclk_s & ~mclk_d;
  wire sclk_fall = ~sclk_s & sclk_d;

  ////////////////////////////////////////////////////////////////////////////
  // Ready strobe pacing
  // Sync low on a master rise overrides every state
  reg [1:0] state;
  reg [7:0] mcnt;
  reg [7:0] dly;

  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= ST_DOWN;
      mcnt <= 8'h00;
      dly <= 8'h00;
      ready_n_o <= 1'b1;
      powered_down_o <= 1'b1;
      result_take_o <= 1'b0;
    end else begin
      result_take_o <= 1'b0;
      if (mclk_rise && !sync_n_s) begin
        // Sync low seen on an edge: enter power-down, strobe goes high
        state <= ST_DOWN;
        mcnt <= 8'h00;
        dly <= SYNC_CYC;
        powered_down_o <= 1'b1;
      end else begin
        case (state)
          ST_DOWN: begin
            if (dly != 8'h00) begin
              dly <= dly - 8'h01;
              if (dly == 8'h01) begin
                ready_n_o <= 1'b1;
              end
            end
            if (mclk_rise && sync_n_s) begin
              // Restart: first strobe fall follows this edge
              powered_down_o <= 1'b0;
              ready_n_o <= 1'b1;
              mcnt <= 8'h00;
              dly <= FALL_CYC;
              state <= ST_FALLW;
            end
          end
          ST_RUN: begin
            if (mclk_rise) begin
              // Period ends on the 8n-th master rise after the last period end
              if (mcnt == PERIOD_MCLK - 8'h01) begin
                mcnt <= 8'h00;
                dly <= FALL_CYC;
                state <= ST_RISEW;
              end else begin
                mcnt <= mcnt + 8'h01;
              end
            end
          end
          ST_RISEW: begin
            // Short high pulse; the fall still counts from the period-end edge
            if (mclk_rise) begin
              mcnt <= mcnt + 8'h01;
            end
            if (dly == RISE_AT) begin
              ready_n_o <= 1'b1;
              state <= ST_FALLW;
            end
            dly <= dly - 8'h01;
          end
          ST_FALLW: begin
            // The word loads at this fall; the take pulse is raised in the same cycle
            if (mclk_rise) begin
              mcnt <= mcnt + 8'h01;
            end
            if (dly == 8'h01) begin
              ready_n_o <= 1'b0;
              result_take_o <= 1'b1;
              state <= ST_RUN;
            end
            dly <= dly - 8'h01;
          end
          default: begin
            state <= ST_DOWN;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial shift-out
  // Only the bits below the MSB are stored; the MSB leaves at load
  reg [WORD_BITS-2:0] shreg;
  // Load on the edge that drops the strobe, so data is valid with it
  wire word_load = (state == ST_FALLW) && (dly == 8'h01) && !(mclk_rise && !sync_n_s);

  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      shreg <= {(WORD_BITS-1){1'b0}};
      serial_result_out_o <= 1'b0;
      serial_result_out_oe_o <= 1'b0;
    end else begin
      // Enable follows select; no gating by strobe so bus sharing is host-led
      serial_result_out_oe_o <= ~sel_n_s;
      if (word_load) begin
        // New word: MSB presented at once, held until the first shift-clock fall
        shreg <= result_i[WORD_BITS-2:0];
        serial_result_out_o <= result_i[WORD_BITS-1];
      end else if (sclk_fall && !sel_n_s) begin
        // Chain bits enter at the bottom, so the first one follows bit 0
        serial_result_out_o <= shreg[WORD_BITS-2];
        shreg <= {shreg[WORD_BITS-3:0], chain_d};
      end
    end
  end
endmodule

// [verilog/dsr_sync2.v]
// Purpose: Two-flop synchroniser for a bundle of asynchronous inputs.
// Assumes: Inputs come from pins outside the system clock domain.
// Notes: First stage feeds only the second stage.
`timescale 1ns/1ps
module dsr_sync2 #(
  parameter WIDTH = 4,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
  input wire clk_sys_i,
  input wire rst_b_i,
  input wire [WIDTH-1:0] async_i,
  output reg [WIDTH-1:0] sync_o
);
  reg [WIDTH-1:0] meta;

  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta <= RST_VAL;
      sync_o <= RST_VAL;
    end else begin
      meta <= async_i;
      sync_o <= meta;
    end
  end
endmodule
